// *** src/psp_top.sv ***
// parallel slave port: host-side byte latches, status flags and interrupts
// ----------------------------------------------------------------------
// Notes on behaviour
// - mode select bit makes the data port a parallel slave port
// - mode turns port E pins 0..2 into read, write, chip select
// - one address: writes go to out latch, reads return in latch in slave mode, synced pins outside it
// - in slave mode data direction register is ignored; host strobes decide
// - host write in progress while chip select and write both low
// - write end sets input-full at Q4 following next Q2
// - write end sets done interrupt flag together with input-full
// - input-full cleared only by firmware reading the in latch or by leaving slave mode
// - second host write before firmware read sets overflow flag
// - host read start clears output-full and drives out latch
// - read end sets done interrupt flag at Q4 after next Q2
// - output-full stays low until firmware writes the out latch
// - outside slave mode full flags clear; overflow kept until cleared
// - done flag sticky until firmware clears; enable bit gates request
// ----------------------------------------------------------------------
`timescale 1ns/10ps
module psp_top import psp_pkg::*; (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire psp_req_s          busReq,
    output logic      [DATA_W-1:0] rdData,
    input  wire logic [DATA_W-1:0] portDIn,
    output logic      [DATA_W-1:0] portDOut,
    output logic      [DATA_W-1:0] portDOe,
    input  wire logic [PE_PINS-1:0] portEIn,
    output logic                   portIrq,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [DATA_W+PE_PINS-1:0] pinSync;
    logic [DATA_W-1:0]         dataSync;
    logic [1:0]                phase;
    logic                      rdN;
    logic                      wrN;
    logic                      csN;
    logic                      modeR;
    logic [PE_PINS-1:0]        peDirR;
    logic [DATA_W-1:0]         pdDirR;
    logic [DATA_W-1:0]         inLatchR;
    logic                      ibfR;
    logic                      obfR;
    logic                      ibovR;
    logic                      pirFlagR;
    logic                      pieR;
    logic [EV_W-1:0]           evStatR;
    logic [EV_W-1:0]           evMaskR;
    logic [EV_W-1:0]           evSet;
    logic                      wrActive;
    logic                      rdActive;
    logic                      wrActiveD;
    logic                      rdActiveD;
    logic                      wrStart;
    logic                      rdStart;
    logic                      ovfSet;
    logic [CHANNELS-1:0]       endEvt;
    logic [CHANNELS-1:0]       done;
    psp_seq_e                  seqState [CHANNELS];
    logic                      portDWrite;
    logic                      portDRead;
    logic                      peWrite;
    logic                      pirWrite;
    logic                      pieWrite;
    logic                      evRead;
    logic                      evMaskWrite;
    logic [DATA_W-1:0]         rdValue;

    // ------------------------------------------------------------------
    // pin synchronisers and phase clock
    // ------------------------------------------------------------------
    // strobes and data share one sync so captured bytes align with strobes
    psp_sync #(
        .WIDTH (DATA_W + PE_PINS)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pinIn    ({portEIn, portDIn}),
        .pinSync  (pinSync)
    );

    psp_phase u_phase (
        .core_clk (core_clk),
        .rst      (rst),
        .phase    (phase)
    );

    assign dataSync = pinSync[DATA_W-1:0];
    assign rdN      = pinSync[DATA_W+PE_RD_PIN];
    assign wrN      = pinSync[DATA_W+PE_WR_PIN];
    assign csN      = pinSync[DATA_W+PE_CS_PIN];

    // ------------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------------
    assign wrActive = modeR & ~csN & ~wrN;
    assign rdActive = modeR & ~csN & ~rdN;
    assign wrStart  = wrActive & ~wrActiveD;
    assign rdStart  = rdActive & ~rdActiveD;
    assign endEvt[CH_WR] = wrActiveD & ~wrActive;
    assign endEvt[CH_RD] = rdActiveD & ~rdActive;
    // a byte still in flight to input-full also counts as unread
    assign ovfSet   = wrStart & (ibfR | (seqState[CH_WR] != SEQ_IDLE));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrActiveD <= 1'b0;
            rdActiveD <= 1'b0;
        end else begin
            wrActiveD <= wrActive;
            rdActiveD <= rdActive;
        end
    end

    // ------------------------------------------------------------------
    // completion sequencers, one per direction
    // ------------------------------------------------------------------
    // an end seen while a sequence runs is merged into it, not queued
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_seq
            assign done[ch] = (seqState[ch] == SEQ_WAIT_Q4) && (phase == PH_Q4);
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    seqState[ch] <= SEQ_IDLE;
                end else begin
                    case (seqState[ch])
                        SEQ_IDLE: begin
                            if (endEvt[ch]) begin
                                seqState[ch] <= SEQ_WAIT_Q2;
                            end
                        end
                        SEQ_WAIT_Q2: begin
                            if (phase == PH_Q2) begin
                                seqState[ch] <= SEQ_WAIT_Q4;
                            end
                        end
                        SEQ_WAIT_Q4: begin
                            if (phase == PH_Q4) begin
                                seqState[ch] <= SEQ_IDLE;
                            end
                        end
                        default: begin
                            seqState[ch] <= SEQ_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------------
    assign portDWrite  = busReq.wr && (busReq.addr == ADDR_PORT_D_LATCH_LATCH);
    assign portDRead   = busReq.rd && (busReq.addr == ADDR_PORT_D_LATCH_LATCH);
    assign peWrite     = busReq.wr && (busReq.addr == ADDR_PORTE_DIR);
    assign pirWrite    = busReq.wr && (busReq.addr == ADDR_PERIPHERAL_IRQ_FLAGS_ONE);
    assign pieWrite    = busReq.wr && (busReq.addr == ADDR_PERIPHERAL_IRQ_ENABLES_ONE);
    assign evRead      = busReq.rd && (busReq.addr == ADDR_EV_STATUS);
    assign evMaskWrite = busReq.wr && (busReq.addr == ADDR_EV_MASK);

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            modeR  <= 1'b0;
            peDirR <= PORTE_DIR_RST;
        end else if (peWrite) begin
            modeR  <= busReq.wdata[PE_MODE_BIT];
            peDirR <= busReq.wdata[PE_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pdDirR <= PORT_D_LATCH_DIR_RST;
        end else if (busReq.wr && (busReq.addr == ADDR_PORT_D_LATCH_DIR)) begin
            pdDirR <= busReq.wdata;
        end
    end

    // ------------------------------------------------------------------
    // data latches and pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            portDOut <= LATCH_RST;
        end else if (portDWrite) begin
            portDOut <= busReq.wdata;
        end
    end

    // sampling every cycle of the strobe keeps the last stable byte
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            inLatchR <= LATCH_RST;
        end else if (wrActive) begin
            inLatchR <= dataSync;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            portDOe <= '0;
        end else if (modeR) begin
            portDOe <= {DATA_W{rdActive}};
        end else begin
            portDOe <= ~pdDirR;
        end
    end

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ibfR <= 1'b0;
        end else if (!modeR) begin
            ibfR <= 1'b0;
        end else if (done[CH_WR]) begin
            ibfR <= 1'b1;
        end else if (portDRead) begin
            ibfR <= 1'b0;
        end
    end

    // firmware refill in the same cycle as a host read start wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            obfR <= 1'b0;
        end else if (!modeR) begin
            obfR <= 1'b0;
        end else if (portDWrite) begin
            obfR <= 1'b1;
        end else if (rdStart) begin
            obfR <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ibovR <= 1'b0;
        end else if (ovfSet) begin
            ibovR <= 1'b1;
        end else if (peWrite && !busReq.wdata[PE_INPUT_OVERFLOW_FLAG_BIT]) begin
            ibovR <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // done interrupt flag and enable
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pirFlagR <= 1'b0;
        end else if (|done) begin
            pirFlagR <= 1'b1;
        end else if (pirWrite) begin
            pirFlagR <= busReq.wdata[PIR_PSP_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pieR <= 1'b0;
        end else if (pieWrite) begin
            pieR <= busReq.wdata[PIE_PSP_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            portIrq <= 1'b0;
        end else begin
            portIrq <= pirFlagR & pieR;
        end
    end

    // ------------------------------------------------------------------
    // event status, mask and summary interrupt
    // ------------------------------------------------------------------
    assign evSet = {ovfSet, done[CH_RD], done[CH_WR]};

    // set beats the clearing read so no event is lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            evStatR <= EV_RST;
        end else begin
            evStatR <= (evRead ? EV_RST : evStatR) | evSet;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            evMaskR <= EV_RST;
        end else if (evMaskWrite) begin
            evMaskR <= busReq.wdata[EV_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evStatR & evMaskR);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        rdValue = '0;
        case (busReq.addr)
            ADDR_PORT_D_LATCH_LATCH: rdValue = modeR ? inLatchR : dataSync;
            ADDR_PORTE_DIR:   rdValue = {ibfR, obfR, ibovR, modeR, 1'b0, peDirR};
            ADDR_PORT_D_LATCH_DIR:   rdValue = pdDirR;
            ADDR_PERIPHERAL_IRQ_FLAGS_ONE:        rdValue = {pirFlagR, 7'h00};
            ADDR_PERIPHERAL_IRQ_ENABLES_ONE:        rdValue = {pieR, 7'h00};
            ADDR_EV_STATUS:   rdValue = {5'h00, evStatR};
            ADDR_EV_MASK:     rdValue = {5'h00, evMaskR};
            default:          rdValue = '0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= busReq.rd ? rdValue : '0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_wrEnd;
        wrActiveD && !wrActive && (seqState[CH_WR] == SEQ_IDLE);
    endsequence

    sequence s_rdEnd;
        rdActiveD && !rdActive && (seqState[CH_RD] == SEQ_IDLE);
    endsequence

    chk_mode_clears_full: assert property (!modeR |=> (!ibfR && !obfR))
        else $error("full flags not clear outside slave mode");

    chk_ibf_on_q4: assert property ($rose(ibfR) |-> $past(phase) == PH_Q4)
        else $error("input-full set outside Q4");

    chk_write_flag_pair: assert property (s_wrEnd ##0 modeR |-> ##[4:7] (ibfR && pirFlagR))
        else $error("write end did not raise input-full and done flag in time");

    chk_ibf_clear_cause: assert property ($fell(ibfR) |-> $past(portDRead) || !$past(modeR))
        else $error("input-full cleared without a latch read");

    chk_overflow_set: assert property ((wrStart && ibfR) |=> ibovR)
        else $error("overflow not flagged on second write");

    chk_read_start_obf: assert property ((rdStart && !portDWrite) |=> (!obfR && portDOe == '1))
        else $error("read start did not clear output-full and drive");

    chk_read_done: assert property (s_rdEnd |-> ##[4:7] pirFlagR)
        else $error("read end did not raise done flag in time");

    chk_obf_refill: assert property ((portDWrite && modeR) |=> obfR)
        else $error("output-full not set by firmware write");

    chk_irq_gating: assert property ((pirFlagR && !pieR) |=> !portIrq)
        else $error("done interrupt not blocked by enable");

    chk_write_capture: assert property (wrActive |=> inLatchR == $past(dataSync))
        else $error("incoming byte not captured during write");

endmodule : psp_top

// *** pkg/psp_pkg.sv ***
// package: register map, field positions, reset values and types of the slave port
package psp_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int DATA_W      = 8;
    localparam int ADDR_W      = 8;
    localparam int PE_PINS     = 3;
    localparam int SYNC_STAGES = 2;
    localparam int CHANNELS    = 2;
    localparam int EV_W        = 3;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_D_LATCH_LATCH = 8'h08;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAGS_ONE        = 8'h0c;
    localparam logic [7:0] ADDR_PORT_D_LATCH_DIR   = 8'h88;
    localparam logic [7:0] ADDR_PORTE_DIR   = 8'h89;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLES_ONE        = 8'h8c;
    localparam logic [7:0] ADDR_EV_STATUS   = 8'h90;
    localparam logic [7:0] ADDR_EV_MASK     = 8'h91;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PE_IBF_BIT  = 7;
    localparam int PE_OBF_BIT  = 6;
    localparam int PE_INPUT_OVERFLOW_FLAG_BIT = 5;
    localparam int PE_MODE_BIT = 4;
    localparam int PE_RD_PIN   = 0;
    localparam int PE_WR_PIN   = 1;
    localparam int PE_CS_PIN   = 2;
    localparam int PIR_PSP_BIT = 7;
    localparam int PIE_PSP_BIT = 7;
    localparam int EV_WR_BIT   = 0;
    localparam int EV_RD_BIT   = 1;
    localparam int EV_OV_BIT   = 2;
    localparam int CH_WR       = 0;
    localparam int CH_RD       = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] LATCH_RST     = 8'h00;
    localparam logic [7:0] PORT_D_LATCH_DIR_RST = 8'hff;
    localparam logic [2:0] PORTE_DIR_RST = 3'h7;
    localparam logic [2:0] EV_RST        = 3'h0;

    // ------------------------------------------------------------------
    // four-phase instruction clock
    // ------------------------------------------------------------------
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q4 = 2'h3;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT_Q2, SEQ_WAIT_Q4} psp_seq_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } psp_req_s;

endpackage : psp_pkg

// *** src/psp_sync.sv ***
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module psp_sync import psp_pkg::*; #(
    parameter int WIDTH = 11
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);

    // ------------------------------------------------------------------
    // stages
    // ------------------------------------------------------------------
    // first stage feeds only the second; nothing else may look at it
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r  <= '1;
            pinSync <= '1;
        end else begin
            meta_r  <= pinIn;
            pinSync <= meta_r;
        end
    end

endmodule : psp_sync

// *** src/psp_phase.sv ***
// free-running four-phase instruction clock counter
`timescale 1ns/10ps
module psp_phase import psp_pkg::*; (
    input  wire logic       core_clk,
    input  wire logic       rst,
    output logic      [1:0] phase
);

    // ------------------------------------------------------------------
    // phase counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase <= PH_Q1;
        end else begin
            phase <= phase + 2'h1;
        end
    end

endmodule : psp_phase

// *** verif/psp_host_model.sv ***
// host model: external byte-wide processor driving the slave port pins
`timescale 1ns/10ps
module psp_host_model import psp_pkg::*; (
    input  wire logic [DATA_W-1:0]  portDOut,
    input  wire logic [DATA_W-1:0]  portDOe,
    input  wire logic               core_clk,
    output logic      [PE_PINS-1:0] portEIn,
    output logic      [DATA_W-1:0]  portDIn
);
    // ------------------------------------------------------------------
    // pin strobes, order rd, wr, cs; no host clock, only levels
    // ------------------------------------------------------------------
    initial begin
        portEIn = 3'h7;
        portDIn = 8'h00;
    end

    task automatic host_write(input logic [DATA_W-1:0] data, input int holdCyc);
        @(posedge core_clk);
        portDIn <= data;
        @(posedge core_clk);
        portEIn <= 3'h1;
        repeat (holdCyc) @(posedge core_clk);
        portEIn <= 3'h7;
        @(posedge core_clk);
        // released bus shows the inverse, so a stale byte cannot pass
        portDIn <= ~data;
    endtask : host_write

    task automatic host_read(input int holdCyc, output logic [DATA_W-1:0] data,
                             output logic [DATA_W-1:0] oe);
        @(posedge core_clk);
        portEIn <= 3'h2;
        repeat (holdCyc) @(posedge core_clk);
        #1;
        data = portDOut;
        oe   = portDOe;
        // release on the next edge, never between edges
        @(posedge core_clk);
        portEIn <= 3'h7;
    endtask : host_read
endmodule : psp_host_model

// *** verif/psp_top_test.sv ***
// testbench: register bus and host pin scenarios for the slave port
`timescale 1ns/10ps
module psp_top_test import psp_pkg::*; ;
    logic              core_clk;
    logic              rst;
    psp_req_s          busReq;
    logic [DATA_W-1:0] rdData;
    logic [DATA_W-1:0] portDIn;
    logic [DATA_W-1:0] portDOut;
    logic [DATA_W-1:0] portDOe;
    logic [2:0]        portEIn;
    logic              portIrq;
    logic              irq;
    logic [7:0]        hd;
    logic [7:0]        ho;
    int                failCount;
    int                nCompared;
    int                cycles;

    psp_top u_dut (.core_clk(core_clk), .rst(rst), .busReq(busReq), .rdData(rdData),
                   .portDIn(portDIn), .portDOut(portDOut), .portDOe(portDOe),
                   .portEIn(portEIn), .portIrq(portIrq), .irq(irq));
    psp_host_model u_host (.core_clk(core_clk), .portDOut(portDOut), .portDOe(portDOe),
                           .portEIn(portEIn), .portDIn(portDIn));

    // ------------------------------------------------------------------
    // clock, watchdog, shared tasks
    // ------------------------------------------------------------------
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failCount++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        busReq <= '0;
    endtask : bus_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        busReq <= '0;
        #1;
        check(rdData, exp);
    endtask : rd_chk

    // bounded wait: a missing completion must not hang the run
    task automatic wait_irq();
        for (int i = 0; i < 20 && irq !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        check({7'h0, irq}, 8'h01);
    endtask : wait_irq

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 8'h00);
        rd_chk(ADDR_PERIPHERAL_IRQ_ENABLES_ONE, 8'h00);
        rd_chk(ADDR_PORTE_DIR, 8'h07);
        rd_chk(ADDR_PORT_D_LATCH_DIR, 8'hff);
        rd_chk(8'h55, 8'h00);
    endtask : t_reset

    task automatic t_write();
        bus_wr(ADDR_EV_MASK, 8'h07);
        bus_wr(ADDR_PORTE_DIR, 8'h17);
        bus_wr(ADDR_PORT_D_LATCH_DIR, 8'h00);
        settle(3);
        check(portDOe, 8'h00);
        u_host.host_write(8'ha5, 6);
        wait_irq();
        rd_chk(ADDR_EV_STATUS, 8'h01);
        rd_chk(ADDR_PORTE_DIR, 8'h97);
        rd_chk(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 8'h80);
        check({7'h0, portIrq}, 8'h00);
        bus_wr(ADDR_PERIPHERAL_IRQ_ENABLES_ONE, 8'h80);
        settle(2);
        check({7'h0, portIrq}, 8'h01);
        bus_wr(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 8'h00);
        settle(2);
        check({7'h0, portIrq}, 8'h00);
        rd_chk(ADDR_PORTE_DIR, 8'h97);
        rd_chk(ADDR_PORT_D_LATCH_LATCH, 8'ha5);
        rd_chk(ADDR_PORTE_DIR, 8'h17);
    endtask : t_write

    task automatic t_overflow();
        u_host.host_write(8'h11, 3);
        wait_irq();
        rd_chk(ADDR_EV_STATUS, 8'h01);
        u_host.host_write(8'h22, 8);
        // overflow raises irq early; wait out the write completion too
        settle(12);
        check({7'h0, irq}, 8'h01);
        rd_chk(ADDR_EV_STATUS, 8'h05);
        rd_chk(ADDR_PORTE_DIR, 8'hb7);
        bus_wr(ADDR_PORTE_DIR, 8'h27);
        rd_chk(ADDR_PORTE_DIR, 8'h27);
        rd_chk(ADDR_PORT_D_LATCH_LATCH, 8'hdd);
        bus_wr(ADDR_PORTE_DIR, 8'h17);
        rd_chk(ADDR_PORT_D_LATCH_LATCH, 8'h22);
        rd_chk(ADDR_PORTE_DIR, 8'h17);
        bus_wr(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 8'h00);
    endtask : t_overflow

    task automatic t_read();
        bus_wr(ADDR_PORT_D_LATCH_LATCH, 8'h3c);
        rd_chk(ADDR_PORTE_DIR, 8'h57);
        bus_wr(ADDR_EV_MASK, 8'h05);
        u_host.host_read(5, hd, ho);
        check(hd, 8'h3c);
        check(ho, 8'hff);
        settle(14);
        check({7'h0, irq}, 8'h00);
        check(portDOe, 8'h00);
        bus_wr(ADDR_EV_MASK, 8'h07);
        settle(2);
        check({7'h0, irq}, 8'h01);
        rd_chk(ADDR_EV_STATUS, 8'h02);
        settle(2);
        check({7'h0, irq}, 8'h00);
        rd_chk(ADDR_PERIPHERAL_IRQ_FLAGS_ONE, 8'h80);
        rd_chk(ADDR_PORTE_DIR, 8'h17);
        bus_wr(ADDR_PORT_D_LATCH_LATCH, 8'hc3);
        rd_chk(ADDR_PORTE_DIR, 8'h57);
        bus_wr(ADDR_PORTE_DIR, 8'h07);
        rd_chk(ADDR_PORTE_DIR, 8'h07);
    endtask : t_read

    initial begin
        rst       = 1'b1;
        busReq    = '0;
        failCount = 0;
        nCompared = 0;
        cycles    = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_write();
        t_overflow();
        t_read();
        wrap_up();
    end
endmodule : psp_top_test
